// File: design/uac_pkg.sv
package uac_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;

    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MID_DATA = 6'h14;
    localparam logic [IDX_W-1:0] IDX_MID_DIR = 6'h16;
    localparam logic [IDX_W-1:0] IDX_MID_FC = 6'h17;
    localparam logic [IDX_W-1:0] IDX_UP_DATA = 6'h18;
    localparam logic [IDX_W-1:0] IDX_UP_DIR = 6'h1a;
    localparam logic [IDX_W-1:0] IDX_UP_FC = 6'h1b;
    localparam logic [IDX_W-1:0] IDX_CTL_DATA = 6'h1c;
    localparam logic [IDX_W-1:0] IDX_CTL_DIR = 6'h1e;
    localparam logic [IDX_W-1:0] IDX_CTL_FC = 6'h1f;
    localparam logic [IDX_W-1:0] IDX_CS_DATA = 6'h20;
    localparam logic [IDX_W-1:0] IDX_CS_FC2 = 6'h21;
    localparam logic [IDX_W-1:0] IDX_CS_DIR = 6'h22;
    localparam logic [IDX_W-1:0] IDX_CS_FC = 6'h23;

    // ****************************************************************
    // reset values and field positions
    // ****************************************************************
    localparam logic [7:0] RST_ADR_LATCH = 8'h00;
    localparam logic [7:0] RST_ADR_DIR = 8'h00;
    localparam logic [7:0] RST_ADR_FC = 8'h00;
    localparam logic [7:0] RST_CTL_LATCH = 8'hcf;
    localparam logic [7:0] RST_CTL_DIR = 8'hc0;
    localparam logic [7:0] RST_CTL_FC = 8'h00;
    localparam logic [3:0] RST_CS_LATCH = 4'hb;
    localparam logic RST_CS_DIR3 = 1'b1;
    localparam logic [3:0] RST_CS_FC = 4'h0;
    localparam logic [7:0] CTL_IMPL_MASK = 8'hdf;
    localparam logic [7:0] CTL_FC_MASK = 8'hdf;
    localparam int CTL_INT_BIT = 4;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // alternate-function sources from the memory controller and timers
    typedef struct packed {
        logic [23:8] addr;
        logic rd_strobe_n;
        logic sram_write_strobe_n;
        logic sram_low_byte_strobe_n;
        logic sram_high_byte_strobe_n;
        logic [3:0] chip_select_n;
        logic timer_one_output;
        logic timer_three_output;
        logic timer_five_output;
    } uac_alt_t;

endpackage : uac_pkg

// File: design/uac_sync.sv
`timescale 1ns/1ps
module uac_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // two-stage pin synchroniser
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : uac_sync

// File: design/uac_axil.sv
`timescale 1ns/1ps
module uac_axil (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [uac_pkg::ADDR_W-1:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [uac_pkg::DATA_W-1:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [uac_pkg::ADDR_W-1:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [uac_pkg::DATA_W-1:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic wr_o,
    output logic [uac_pkg::IDX_W-1:0] wr_idx_o,
    output logic [7:0] wr_data_o,
    input wire logic wr_err_i,
    output logic [uac_pkg::IDX_W-1:0] rd_idx_o,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_err_i,
    output logic rd_o
);
    logic aw_have_q;
    logic w_have_q;
    logic wr_go;

    assign wr_go = aw_have_q && w_have_q && !bvalid_o && !wr_o;
    assign rd_idx_o = araddr_i[uac_pkg::ADDR_W-1:2];

    // write address and data accepted in either order
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_o <= 1'b1;
            wready_o <= 1'b1;
            wr_idx_o <= '0;
            wr_data_o <= '0;
            wr_o <= 1'b0;
        end else begin
            wr_o <= wr_go;
            if (awvalid_i && awready_o) begin
                aw_have_q <= 1'b1;
                awready_o <= 1'b0;
                wr_idx_o <= awaddr_i[uac_pkg::ADDR_W-1:2];
            end
            if (wvalid_i && wready_o) begin
                w_have_q <= 1'b1;
                wready_o <= 1'b0;
                wr_data_o <= wdata_i[7:0];
                if (!wstrb_i[0]) begin
                    wr_data_o <= '0;
                end
            end
            if (wr_o) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
            if (bvalid_o && bready_i) begin
                awready_o <= 1'b1;
                wready_o <= 1'b1;
            end
        end
    end

    // write response raised at the same edge as the register update
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bvalid_o <= 1'b0;
            bresp_o <= uac_pkg::AXI_OKAY;
        end else if (wr_o) begin
            bvalid_o <= 1'b1;
            bresp_o <= wr_err_i ? uac_pkg::AXI_SLVERR : uac_pkg::AXI_OKAY;
        end else if (bvalid_o && bready_i) begin
            bvalid_o <= 1'b0;
        end
    end

    // read channel, data captured at the address handshake
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            arready_o <= 1'b1;
            rvalid_o <= 1'b0;
            rdata_o <= '0;
            rresp_o <= uac_pkg::AXI_OKAY;
            rd_o <= 1'b0;
        end else begin
            rd_o <= arvalid_i && arready_o;
            if (arvalid_i && arready_o) begin
                arready_o <= 1'b0;
                rvalid_o <= 1'b1;
                rdata_o <= {24'h000000, rd_data_i};
                rresp_o <= rd_err_i ? uac_pkg::AXI_SLVERR : uac_pkg::AXI_OKAY;
            end else if (rvalid_o && rready_i) begin
                rvalid_o <= 1'b0;
                arready_o <= 1'b1;
            end
        end
    end
endmodule : uac_axil

// File: design/uac_ports.sv
`timescale 1ns/1ps
// Behaviour
// RQ1: middle function bit drives A8..A15, resets 0
// RQ2: software avoids read-modify-write on address ports
// RQ3: software writes direction before function
// RQ4: upper port eight pins, direction per bit
// RQ5: upper function bit routes A16..A23
// RQ6: upper reset inputs, reads pins, latch zero
// RQ7: control bits 0-3,6,7 bidir, 4 input, 5 absent
// RQ8: control bits 6,7 are open drain outputs
// RQ9: control latch drives pull-ups in input mode
// RQ10: control function bits select strobes and interrupt
// RQ11: control alternates need direction and function set; the bit 4 interrupt uses only its function bit
// RQ12: control reset: 0-4 inputs, 6,7 released outputs
// RQ13: software sets resonator direction and data codes
// RQ14: software avoids read-modify-write on control registers
// RQ15: chip-select port three outputs, one bidir
// RQ16: chip-select alternates: selects, timers, wait input
// RQ17: chip-select function registers reset to port
// RQ18: chip-select latch resets to 1,1,0,1
// RQ19: software sets wait mode by direction/function
// RQ20: software writes chip-select function before direction
// RQ21: control bit 4 reads live pin, ignores writes
// RQ22: alternate source drives pin, latch keeps value
module uac_ports (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [uac_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [uac_pkg::DATA_W-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [uac_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [uac_pkg::DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire uac_pkg::uac_alt_t alt_i,
    input wire logic [7:0] mid_pin_i,
    output logic [7:0] mid_pin_o,
    output logic [7:0] mid_pin_oe_o,
    input wire logic [7:0] up_pin_i,
    output logic [7:0] up_pin_o,
    output logic [7:0] up_pin_oe_o,
    input wire logic [7:0] ctl_pin_i,
    output logic [7:0] ctl_pin_o,
    output logic [7:0] ctl_pin_oe_o,
    output logic [3:0] ctl_pullup_en_o,
    output logic external_interrupt_zero_o,
    output logic resonator_en_o,
    input wire logic [3:0] cs_pin_i,
    output logic [3:0] cs_pin_o,
    output logic [3:0] cs_pin_oe_o,
    output logic wait_n_o
);
    // ****************************************************************
    // bus slave and pin synchronisers
    // ****************************************************************
    logic wr;
    logic rd;
    logic [uac_pkg::IDX_W-1:0] wr_idx;
    logic [uac_pkg::IDX_W-1:0] rd_idx;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic rd_err;
    logic wr_err;
    logic [7:0] mid_in;
    logic [7:0] up_in;
    logic [7:0] ctl_in;
    logic [3:0] cs_in;

    uac_axil u_axil (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .awaddr_i(s_axi_awaddr_i),
        .awvalid_i(s_axi_awvalid_i),
        .awready_o(s_axi_awready_o),
        .wdata_i(s_axi_wdata_i),
        .wstrb_i(s_axi_wstrb_i),
        .wvalid_i(s_axi_wvalid_i),
        .wready_o(s_axi_wready_o),
        .bresp_o(s_axi_bresp_o),
        .bvalid_o(s_axi_bvalid_o),
        .bready_i(s_axi_bready_i),
        .araddr_i(s_axi_araddr_i),
        .arvalid_i(s_axi_arvalid_i),
        .arready_o(s_axi_arready_o),
        .rdata_o(s_axi_rdata_o),
        .rresp_o(s_axi_rresp_o),
        .rvalid_o(s_axi_rvalid_o),
        .rready_i(s_axi_rready_i),
        .wr_o(wr),
        .wr_idx_o(wr_idx),
        .wr_data_o(wr_data),
        .wr_err_i(wr_err),
        .rd_idx_o(rd_idx),
        .rd_data_i(rd_data),
        .rd_err_i(rd_err),
        .rd_o(rd)
    );

    uac_sync #(.W(28)) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .d_i({cs_pin_i, ctl_pin_i, up_pin_i, mid_pin_i}),
        .q_o({cs_in, ctl_in, up_in, mid_in})
    );

    // ****************************************************************
    // register file
    // ****************************************************************
    logic [7:0] mid_latch_q;
    logic [7:0] mid_dir_q;
    logic [7:0] mid_fc_q;
    logic [7:0] up_latch_q;
    logic [7:0] up_dir_q;
    logic [7:0] up_fc_q;
    logic [7:0] ctl_latch_q;
    logic [7:0] ctl_dir_q;
    logic [7:0] ctl_fc_q;
    logic [3:0] cs_latch_q;
    logic cs_dir3_q;
    logic [3:0] cs_fc_q;
    logic [3:0] cs_fc2_q;

    // address ports: data, direction, function
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mid_latch_q <= uac_pkg::RST_ADR_LATCH;
            mid_dir_q <= uac_pkg::RST_ADR_DIR;
            mid_fc_q <= uac_pkg::RST_ADR_FC; // RQ1
            up_latch_q <= uac_pkg::RST_ADR_LATCH; // RQ6
            up_dir_q <= uac_pkg::RST_ADR_DIR; // RQ4
            up_fc_q <= uac_pkg::RST_ADR_FC; // RQ6
        end else if (wr) begin
            if (wr_idx == uac_pkg::IDX_MID_DATA) mid_latch_q <= wr_data;
            if (wr_idx == uac_pkg::IDX_MID_DIR) mid_dir_q <= wr_data;
            if (wr_idx == uac_pkg::IDX_MID_FC) mid_fc_q <= wr_data;
            if (wr_idx == uac_pkg::IDX_UP_DATA) up_latch_q <= wr_data;
            if (wr_idx == uac_pkg::IDX_UP_DIR) up_dir_q <= wr_data; // RQ4
            if (wr_idx == uac_pkg::IDX_UP_FC) up_fc_q <= wr_data;
        end
    end

    // control port, unimplemented bits held at zero
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctl_latch_q <= uac_pkg::RST_CTL_LATCH;
            ctl_dir_q <= uac_pkg::RST_CTL_DIR; // RQ12
            ctl_fc_q <= uac_pkg::RST_CTL_FC;
        end else if (wr) begin
            if (wr_idx == uac_pkg::IDX_CTL_DATA) begin
                ctl_latch_q <= (wr_data & 8'hcf) | (ctl_latch_q & 8'h10); // RQ21
            end
            if (wr_idx == uac_pkg::IDX_CTL_DIR) ctl_dir_q <= wr_data & 8'hcf; // RQ7
            if (wr_idx == uac_pkg::IDX_CTL_FC) ctl_fc_q <= wr_data & uac_pkg::CTL_FC_MASK;
        end
    end

    // chip-select port
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cs_latch_q <= uac_pkg::RST_CS_LATCH; // RQ18
            cs_dir3_q <= uac_pkg::RST_CS_DIR3;
            cs_fc_q <= uac_pkg::RST_CS_FC; // RQ17
            cs_fc2_q <= uac_pkg::RST_CS_FC; // RQ17
        end else if (wr) begin
            if (wr_idx == uac_pkg::IDX_CS_DATA) cs_latch_q <= wr_data[3:0];
            if (wr_idx == uac_pkg::IDX_CS_DIR) cs_dir3_q <= wr_data[3];
            if (wr_idx == uac_pkg::IDX_CS_FC) cs_fc_q <= wr_data[3:0];
            if (wr_idx == uac_pkg::IDX_CS_FC2) cs_fc2_q <= wr_data[3:0] & 4'hb;
        end
    end

    // decode of mapped indices
    function automatic logic mapped(input logic [uac_pkg::IDX_W-1:0] idx);
        mapped = (idx == uac_pkg::IDX_MID_DATA) || (idx == uac_pkg::IDX_MID_DIR) ||
            (idx == uac_pkg::IDX_MID_FC) || (idx == uac_pkg::IDX_UP_DATA) ||
            (idx == uac_pkg::IDX_UP_DIR) || (idx == uac_pkg::IDX_UP_FC) ||
            (idx == uac_pkg::IDX_CTL_DATA) || (idx == uac_pkg::IDX_CTL_DIR) ||
            (idx == uac_pkg::IDX_CTL_FC) || (idx == uac_pkg::IDX_CS_DATA) ||
            (idx == uac_pkg::IDX_CS_DIR) || (idx == uac_pkg::IDX_CS_FC) ||
            (idx == uac_pkg::IDX_CS_FC2);
    endfunction : mapped

    assign wr_err = !mapped(wr_idx);
    assign rd_err = !mapped(rd_idx);

    // ****************************************************************
    // read mux, write-only registers read as zero
    // ****************************************************************
    always_comb begin
        rd_data = 8'h00;
        unique case (rd_idx)
            uac_pkg::IDX_MID_DATA: rd_data = (mid_dir_q & mid_latch_q) | (~mid_dir_q & mid_in);
            uac_pkg::IDX_UP_DATA: rd_data = (up_dir_q & up_latch_q) | (~up_dir_q & up_in); // RQ6
            uac_pkg::IDX_CTL_DATA: begin
                rd_data = ((ctl_dir_q & ctl_latch_q) | (~ctl_dir_q & ctl_in)) &
                    uac_pkg::CTL_IMPL_MASK; // RQ7
                rd_data[uac_pkg::CTL_INT_BIT] = ctl_in[uac_pkg::CTL_INT_BIT]; // RQ21
            end
            uac_pkg::IDX_CS_DATA: begin
                rd_data[2:0] = cs_latch_q[2:0];
                rd_data[3] = cs_dir3_q ? cs_latch_q[3] : cs_in[3];
            end
            default: rd_data = 8'h00;
        endcase
    end

    // ****************************************************************
    // pin drive, registered
    // ****************************************************************
    logic [7:0] ctl_alt_en;
    logic [3:0] ctl_strobe;
    assign ctl_alt_en = ctl_dir_q & ctl_fc_q; // RQ11
    assign ctl_strobe = {alt_i.sram_high_byte_strobe_n, alt_i.sram_low_byte_strobe_n,
        alt_i.sram_write_strobe_n, alt_i.rd_strobe_n}; // RQ10

    // address port pins, one slice per bit
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_adr
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    mid_pin_o[gi] <= 1'b0;
                    mid_pin_oe_o[gi] <= 1'b0;
                    up_pin_o[gi] <= 1'b0;
                    up_pin_oe_o[gi] <= 1'b0;
                end else begin
                    mid_pin_o[gi] <= mid_fc_q[gi] ? alt_i.addr[8+gi] : mid_latch_q[gi]; // RQ1
                    mid_pin_oe_o[gi] <= mid_dir_q[gi];
                    up_pin_o[gi] <= up_fc_q[gi] ? alt_i.addr[16+gi] : up_latch_q[gi]; // RQ5
                    up_pin_oe_o[gi] <= up_dir_q[gi]; // RQ4
                end
            end
        end
    endgenerate

    // control port pins
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctl_pin_o <= 8'h00;
            ctl_pin_oe_o <= 8'h00;
            ctl_pullup_en_o <= 4'h0;
            external_interrupt_zero_o <= 1'b1;
            resonator_en_o <= 1'b0;
        end else begin
            for (int b = 0; b < 4; b++) begin
                ctl_pin_o[b] <= ctl_alt_en[b] ? ctl_strobe[b] : ctl_latch_q[b]; // RQ22
                ctl_pin_oe_o[b] <= ctl_dir_q[b];
            end
            ctl_pin_o[7:4] <= 4'h0; // RQ8
            ctl_pin_oe_o[5:4] <= 2'b00; // RQ7
            ctl_pin_oe_o[7:6] <= ctl_dir_q[7:6] & ~ctl_latch_q[7:6] & ~ctl_alt_en[7:6]; // RQ8
            ctl_pullup_en_o <= ~ctl_dir_q[3:0] & ctl_latch_q[3:0]; // RQ9
            external_interrupt_zero_o <= ctl_fc_q[uac_pkg::CTL_INT_BIT] ?
                ctl_in[uac_pkg::CTL_INT_BIT] : 1'b1; // RQ10
            resonator_en_o <= &ctl_alt_en[7:6]; // RQ11
        end
    end

    // chip-select port pins
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cs_pin_o <= uac_pkg::RST_CS_LATCH;
            cs_pin_oe_o <= 4'hf;
            wait_n_o <= 1'b1;
        end else begin
            cs_pin_o[0] <= cs_fc2_q[0] ? alt_i.timer_one_output :
                (cs_fc_q[0] ? alt_i.chip_select_n[0] : cs_latch_q[0]); // RQ16
            cs_pin_o[1] <= cs_fc2_q[1] ? alt_i.timer_three_output :
                (cs_fc_q[1] ? alt_i.chip_select_n[1] : cs_latch_q[1]); // RQ16
            cs_pin_o[2] <= cs_fc_q[2] ? alt_i.chip_select_n[2] : cs_latch_q[2]; // RQ22
            cs_pin_o[3] <= cs_fc2_q[3] ? alt_i.timer_five_output :
                (cs_fc_q[3] ? alt_i.chip_select_n[3] : cs_latch_q[3]); // RQ16
            cs_pin_oe_o <= {cs_dir3_q, 3'b111}; // RQ15
            wait_n_o <= (cs_fc_q[3] && !cs_fc2_q[3] && !cs_dir3_q) ? cs_in[3] : 1'b1; // RQ19
        end
    end

    // read strobe seen by nothing else yet
    logic unused_rd;
    assign unused_rd = rd;
endmodule : uac_ports

// File: dv/uac_pins_model.sv
`timescale 1ns/1ps
module uac_pins_model #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic [W-1:0] o_i,
    input wire logic [W-1:0] oe_i,
    input wire logic [W-1:0] pull_i,
    input wire logic [W-1:0] ext_i,
    input wire logic [W-1:0] ext_en_i,
    output logic [W-1:0] pin_o
);
    // ****************
    // board side of the pins
    // ****************
    logic [W-1:0] float_q = '0;
    // lines nobody drives or pulls wander every cycle
    always_ff @(posedge clk_i) begin
        float_q <= ~float_q;
    end
    // device drive wins, then the board, then the pull-up
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe_i[i]) begin
                pin_o[i] = o_i[i];
            end else if (ext_en_i[i]) begin
                pin_o[i] = ext_i[i];
            end else if (pull_i[i]) begin
                pin_o[i] = 1'h1;
            end else begin
                pin_o[i] = float_q[i];
            end
        end
    end
endmodule : uac_pins_model

// File: dv/uac_props.sv
`timescale 1ns/1ps
module uac_props (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] ctl_pin_i,
    input wire logic [3:0] cs_pin_i,
    input wire logic [7:0] up_pin_oe_o,
    input wire logic [7:0] ctl_pin_o,
    input wire logic [7:0] ctl_pin_oe_o,
    input wire logic [3:0] ctl_pullup_en_o,
    input wire logic external_interrupt_zero_o,
    input wire logic resonator_en_o,
    input wire logic [3:0] cs_pin_o,
    input wire logic [3:0] cs_pin_oe_o,
    input wire logic wait_n_o
);
    // ****************
    // pin output relations
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    chk_reset_cs: assert property ($fell(reset_i) |-> cs_pin_o == 4'hb && cs_pin_oe_o == 4'hf)
        else $error("chip-select pins wrong after reset");
    chk_reset_ctl: assert property ($fell(reset_i) |-> ctl_pin_oe_o == 8'h00
        && up_pin_oe_o == 8'h00 && !resonator_en_o) else $error("port pins wrong after reset");
    chk_cs_out_only: assert property (cs_pin_oe_o[2:0] == 3'h7)
        else $error("chip-select output pin released");
    chk_ctl_absent: assert property (ctl_pin_oe_o[5:4] == 2'h0)
        else $error("control bit 4 or 5 driven");
    chk_open_drain: assert property (ctl_pin_o[7:6] == 2'h0)
        else $error("open-drain pin driven high");
    chk_pullup_input: assert property ((ctl_pullup_en_o & ctl_pin_oe_o[3:0]) == 4'h0)
        else $error("pull-up on a driven pin");
    chk_resonator_pins: assert property (resonator_en_o |-> ctl_pin_oe_o[7:6] == 2'h0)
        else $error("resonator pins still driven");
    chk_int_source: assert property ($fell(external_interrupt_zero_o) |->
        !$past(ctl_pin_i[4], 2) || !$past(ctl_pin_i[4], 3) || !$past(ctl_pin_i[4], 4))
        else $error("interrupt fell without low pin");
    chk_wait_input: assert property (!wait_n_o |-> !cs_pin_oe_o[3] &&
        (!$past(cs_pin_i[3], 2) || !$past(cs_pin_i[3], 3) || !$past(cs_pin_i[3], 4)))
        else $error("wait asserted without low input");
endmodule : uac_props
bind uac_ports uac_props u_uac_props (.clk_i(clk_i), .reset_i(reset_i),
    .ctl_pin_i(ctl_pin_i), .cs_pin_i(cs_pin_i), .up_pin_oe_o(up_pin_oe_o),
    .ctl_pin_o(ctl_pin_o), .ctl_pin_oe_o(ctl_pin_oe_o), .ctl_pullup_en_o(ctl_pullup_en_o),
    .external_interrupt_zero_o(external_interrupt_zero_o), .resonator_en_o(resonator_en_o),
    .cs_pin_o(cs_pin_o), .cs_pin_oe_o(cs_pin_oe_o), .wait_n_o(wait_n_o));

// File: dv/uac_ports_tb.sv
`timescale 1ns/1ps
module uac_ports_tb;
    // ****************
    // stimulus and observation
    // ****************
    logic clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, bd;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    uac_pkg::uac_alt_t alt = '0;
    logic [7:0] mid_i, mid_o, mid_oe, up_i, up_o, up_oe, ctl_i, ctl_o, ctl_oe;
    logic [7:0] ctl_x = 8'hff, mid_x = 8'h3c, up_x = 8'ha5;
    logic [3:0] pull, cs_i, cs_o, cs_oe, wstrb = 4'hf, cs_x = 4'h0;
    logic external_interrupt_zero, res_en, wait_n;
    int n_errors = 0, checks_done = 0;
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    uac_ports u_uac_ports (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .alt_i(alt), .mid_pin_i(mid_i), .mid_pin_o(mid_o),
        .mid_pin_oe_o(mid_oe), .up_pin_i(up_i), .up_pin_o(up_o), .up_pin_oe_o(up_oe),
        .ctl_pin_i(ctl_i), .ctl_pin_o(ctl_o), .ctl_pin_oe_o(ctl_oe), .ctl_pullup_en_o(pull),
        .external_interrupt_zero_o(external_interrupt_zero), .resonator_en_o(res_en), .cs_pin_i(cs_i),
        .cs_pin_o(cs_o), .cs_pin_oe_o(cs_oe), .wait_n_o(wait_n));
    // board side of each port
    uac_pins_model u_mid (.clk_i(clk_i), .o_i(mid_o), .oe_i(mid_oe), .pull_i(8'h00),
        .ext_i(mid_x), .ext_en_i(~mid_oe), .pin_o(mid_i));
    uac_pins_model u_up (.clk_i(clk_i), .o_i(up_o), .oe_i(up_oe), .pull_i(8'h00),
        .ext_i(up_x), .ext_en_i(~up_oe), .pin_o(up_i));
    uac_pins_model u_ctl (.clk_i(clk_i), .o_i(ctl_o), .oe_i(ctl_oe), .pull_i({4'h0, pull}),
        .ext_i(ctl_x), .ext_en_i(8'h10), .pin_o(ctl_i));
    uac_pins_model #(.W(4)) u_cs (.clk_i(clk_i), .o_i(cs_o), .oe_i(cs_oe), .pull_i(4'h0),
        .ext_i(cs_x), .ext_en_i(~cs_oe), .pin_o(cs_i));
    // ****************
    // tasks
    // ****************
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic axw(input logic [5:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        fork
            begin
                do @(posedge clk_i); while (!awready);
                awvalid <= 1'h0;
            end
            begin
                do @(posedge clk_i); while (!wready);
                wvalid <= 1'h0;
            end
        join
        do @(posedge clk_i); while (!bvalid);
        bready <= 1'h0;
        rs = bresp;
    endtask : axw
    task automatic axr(input logic [5:0] idx);
        @(posedge clk_i);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk_i); while (!arready);
        arvalid <= 1'h0;
        do @(posedge clk_i); while (!rvalid);
        rready <= 1'h0;
        bd = rdata[7:0];
        rs = rresp;
    endtask : axr
    task automatic settle;
        repeat (4) @(posedge clk_i);
        #1;
    endtask : settle
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    // hang guard, far beyond the test length
    initial begin
        #2000000;
        n_errors++;
        give_verdict();
    end
    // ****************
    // test sequence
    // ****************
    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'h0;
        settle();
        cmp("cs_o", 4'hb, cs_o);
        cmp("cs_oe", 4'hf, cs_oe);
        cmp("up_oe", 8'h00, up_oe);
        cmp("ctl_oe", 8'h00, ctl_oe);
        cmp("pull", 4'hf, pull);
        axr(uac_pkg::IDX_UP_DATA);
        cmp("up_rd", 8'ha5, bd);
        axr(uac_pkg::IDX_UP_DIR);
        cmp("dir_rd", 8'h00, bd);
        // address ports: direction first, then function
        axw(uac_pkg::IDX_UP_DATA, 8'h5a);
        axw(uac_pkg::IDX_UP_DIR, 8'hff);
        alt.addr <= 16'hc396;
        axw(uac_pkg::IDX_UP_FC, 8'h0f);
        axw(uac_pkg::IDX_MID_DIR, 8'hff);
        axw(uac_pkg::IDX_MID_FC, 8'hff);
        settle();
        cmp("up_o", 8'h53, up_o);
        cmp("up_oe", 8'hff, up_oe);
        cmp("mid_o", 8'h96, mid_o);
        cmp("mid_oe", 8'hff, mid_oe);
        axr(uac_pkg::IDX_UP_DATA);
        cmp("up_latch", 8'h5a, bd);
        // control port: input-only bit, pull-ups, strobes, resonator
        axr(uac_pkg::IDX_CTL_DATA);
        cmp("ctl_b4_hi", 8'h10, bd & 8'h10);
        ctl_x <= 8'h00;
        axw(uac_pkg::IDX_CTL_DATA, 8'h30);
        settle();
        cmp("pull_off", 4'h0, pull);
        cmp("od_oe", 2'h3, ctl_oe[7:6]);
        axr(uac_pkg::IDX_CTL_DATA);
        cmp("ctl_b4", 8'h00, bd & 8'h10);
        alt.rd_strobe_n <= 1'h1;
        alt.sram_low_byte_strobe_n <= 1'h1;
        axw(uac_pkg::IDX_CTL_FC, 8'h1f);
        settle();
        cmp("alt_no_dir", 4'h0, ctl_oe[3:0]);
        cmp("external_interrupt_zero", 1'h0, external_interrupt_zero);
        axw(uac_pkg::IDX_CTL_DIR, 8'hcf);
        settle();
        cmp("strobes", 4'h5, ctl_o[3:0]);
        cmp("strobe_oe", 4'hf, ctl_oe[3:0]);
        axw(uac_pkg::IDX_CTL_FC, 8'hdf);
        settle();
        cmp("res_en", 1'h1, res_en);
        cmp("res_oe", 2'h0, ctl_oe[7:6]);
        // chip-select port: selects, timer, then direction before wait function
        alt.chip_select_n <= 4'h6;
        alt.timer_one_output <= 1'h1;
        axw(uac_pkg::IDX_CS_FC, 8'h07);
        settle();
        cmp("cs_sel", 3'h6, cs_o[2:0]);
        axw(uac_pkg::IDX_CS_FC2, 8'h01);
        settle();
        cmp("cs_tmr", 1'h1, cs_o[0]);
        axw(uac_pkg::IDX_CS_DIR, 8'h00);
        axw(uac_pkg::IDX_CS_FC, 8'h08);
        settle();
        cmp("cs3_oe", 1'h0, cs_oe[3]);
        cmp("wait_n", 1'h0, wait_n);
        cs_x <= 4'h8;
        settle();
        cmp("wait_hi", 1'h1, wait_n);
        // unmapped place
        axw(6'h3f, 8'hff);
        cmp("wr_resp", uac_pkg::AXI_SLVERR, rs);
        axr(6'h3f);
        cmp("rd_resp", uac_pkg::AXI_SLVERR, rs);
        cmp("rd_data", 32'h0, rdata);
        give_verdict();
    end
endmodule : uac_ports_tb
